// *** design/fmc_regs.vh ***
// constants for the flash mode controller
`ifndef FMC_REGS_VH
`define FMC_REGS_VH
// user command codes
`define FMC_OP_READ 3'h0
`define FMC_OP_WRITE 3'h1
`define FMC_OP_ID_HV 3'h2
`define FMC_OP_ID_CMD 3'h3
`define FMC_OP_RESET 3'h4
`define FMC_OP_PROTECT 3'h5
`define FMC_OP_UNPROT_TMP 3'h6
`define FMC_OP_UNPROT_END 3'h7
// identification address fields
`define FMC_ID_SEL_MFR 3'h0
`define FMC_ID_SEL_DEV 3'h1
`define FMC_ID_SEL_PROT 3'h2
`define FMC_SECT_LSB 12
`define FMC_SECT_MSB 17
// command bus words
`define FMC_UNLOCK1_ADDR 18'h00555
`define FMC_UNLOCK1_DATA 8'hAA
`define FMC_UNLOCK2_ADDR 18'h002AA
`define FMC_UNLOCK2_DATA 8'h55
`define FMC_ID_CMD_DATA 8'h90
`define FMC_RESET_DATA 8'hF0
// timing: strobe phases, 25 ns cycles each
`define FMC_T_SETUP_NS 50
`define FMC_T_PULSE_NS 50
`define FMC_T_HOLD_NS 25
`define FMC_T_READ_NS 75
`define FMC_CLK_NS 25
`define FMC_T_SETUP_CYC ((`FMC_T_SETUP_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS)
`define FMC_T_PULSE_CYC ((`FMC_T_PULSE_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS)
`define FMC_T_HOLD_CYC ((`FMC_T_HOLD_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS)
`define FMC_T_READ_CYC ((`FMC_T_READ_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS)
`endif

// *** design/fmc_bus_cycle.v ***
// one bus cycle (read or write) on the flash strobes
`timescale 1ns/1ps
`default_nettype none
`include "fmc_regs.vh"
module fmc_bus_cycle (
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  input wire start,
  input wire is_write,
  input wire [17:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] dq_in,
  output reg busy_reg,
  output reg done_reg,
  output reg [7:0] rdata_reg,
  output reg [17:0] flash_addr_reg,
  output reg [7:0] dq_out_reg,
  output reg dq_oe_n_reg,
  output reg chip_sel_n_reg,
  output reg out_en_n_reg,
  output reg wr_strobe_n_reg
);
  localparam PH_IDLE = 2'h0;
  localparam PH_SETUP = 2'h1;
  localparam PH_PULSE = 2'h2;
  localparam PH_HOLD = 2'h3;
  // counts cut to the counter width on purpose; all fit in four bits
  localparam [31:0] SETUP_W = `FMC_T_SETUP_CYC;
  localparam [31:0] PULSE_W = `FMC_T_PULSE_CYC;
  localparam [31:0] READ_W = `FMC_T_READ_CYC;
  localparam [31:0] HOLD_W = `FMC_T_HOLD_CYC;
  localparam [3:0] SETUP_CYC = SETUP_W[3:0];
  localparam [3:0] PULSE_CYC = PULSE_W[3:0];
  localparam [3:0] READ_CYC = READ_W[3:0];
  localparam [3:0] HOLD_CYC = HOLD_W[3:0];
  reg [1:0] phase_reg;
  reg [3:0] cnt_reg;
  reg wr_reg;
  reg [7:0] dq_s1_reg;
  reg [7:0] dq_s2_reg;

  // read data comes from the pins, so two flops first
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else if (clk_en) begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // strobe sequencer; address settles before any strobe falls
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= PH_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 8'h00;
      flash_addr_reg <= 18'h00000;
      dq_out_reg <= 8'h00;
      dq_oe_n_reg <= 1'b1;
      chip_sel_n_reg <= 1'b1;
      out_en_n_reg <= 1'b1;
      wr_strobe_n_reg <= 1'b1;
    end else if (clk_en) begin
      done_reg <= 1'b0;
      case (phase_reg)
        PH_IDLE: begin
          if (start) begin
            busy_reg <= 1'b1;
            wr_reg <= is_write;
            flash_addr_reg <= addr;
            dq_out_reg <= wdata;
            // oe high first so a write is never inhibited
            out_en_n_reg <= 1'b1;
            cnt_reg <= SETUP_CYC;
            phase_reg <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          if (cnt_reg == 4'h1) begin
            chip_sel_n_reg <= 1'b0;
            // address latched at the later fall: ce and we fall together
            wr_strobe_n_reg <= ~wr_reg;
            out_en_n_reg <= wr_reg;
            dq_oe_n_reg <= ~wr_reg;
            cnt_reg <= wr_reg ? PULSE_CYC : READ_CYC;
            phase_reg <= PH_PULSE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        PH_PULSE: begin
          if (cnt_reg == 4'h1) begin
            // we rises first, data still held on the bus
            wr_strobe_n_reg <= 1'b1;
            out_en_n_reg <= 1'b1;
            cnt_reg <= HOLD_CYC;
            phase_reg <= PH_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: begin
          if (cnt_reg == 4'h1) begin
            // pins lag one flop and data two more, so take it this late
            if (!wr_reg)
              rdata_reg <= dq_s2_reg;
            chip_sel_n_reg <= 1'b1;
            dq_oe_n_reg <= 1'b1;
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            phase_reg <= PH_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
      endcase
    end
  end
endmodule // fmc_bus_cycle
`default_nettype wire

// *** design/fmc_host_ctrl.v ***
// host-side controller for flash identification and protection modes
// What this block does
// - drives high-voltage qualifier on address line nine for identification reads
// - id reads select code by A1, A0 with A6 held low; sector on A17..A12
// - in-system identification by unlock cycles plus identify command
// - protection set only with qualifier on line nine and oe
// - reset-pin qualifier unprotects temporarily; removal re-protects
// - unlock cycles precede the identify command
// - write needs chip select and write strobe low, oe high
// - host writes reset to leave identification or timing-limit state
`timescale 1ns/1ps
`default_nettype none
`include "fmc_regs.vh"
module fmc_host_ctrl (
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  // user command port
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [17:0] cmd_addr,
  input wire [7:0] cmd_data,
  output reg cmd_ready_reg,
  output reg rsp_valid_reg,
  output reg [7:0] rsp_data_reg,
  output reg id_mode_reg,
  output reg unprot_tmp_reg,
  // flash pins
  output reg [17:0] flash_addr_reg,
  input wire [7:0] dq_in,
  output reg [7:0] dq_out_reg,
  output reg dq_oe_n_reg,
  output reg chip_sel_n_reg,
  output reg out_en_n_reg,
  output reg wr_strobe_n_reg,
  output reg hv_addr_line_nine_reg,
  output reg hv_out_en_reg,
  output reg hv_reset_reg,
  input wire timing_limit_flag
);
  localparam ST_IDLE = 3'h0;
  localparam ST_BUS = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_NEXT = 3'h3;
  localparam ST_DONE = 3'h4;

  reg [2:0] state_reg;
  reg [2:0] op_reg;
  reg [17:0] addr_reg;
  reg [7:0] data_reg;
  reg [1:0] step_reg;
  reg bc_start_reg;
  reg bc_write_reg;
  reg [17:0] bc_addr_reg;
  reg [7:0] bc_wdata_reg;
  reg tlf_s1_reg;
  reg tlf_s2_reg;
  reg tlf_seen_reg;
  wire bc_busy;
  wire bc_done;
  wire [7:0] bc_rdata;
  wire [17:0] p_addr;
  wire [7:0] p_dq;
  wire p_oe_n;
  wire p_ce_n;
  wire p_out_n;
  wire p_we_n;

  // identification address: sel picks manufacturer, device or protect
  function [17:0] id_addr;
    input [2:0] sel;
    input [17:0] base;
    begin
      id_addr = {base[`FMC_SECT_MSB:`FMC_SECT_LSB], 12'h000};
      if (sel == `FMC_ID_SEL_DEV)
        id_addr[0] = 1'b1;
      else if (sel == `FMC_ID_SEL_PROT)
        id_addr[1] = 1'b1;
    end
  endfunction

  fmc_bus_cycle u_cycle (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .start(bc_start_reg),
    .is_write(bc_write_reg),
    .addr(bc_addr_reg),
    .wdata(bc_wdata_reg),
    .dq_in(dq_in),
    .busy_reg(bc_busy),
    .done_reg(bc_done),
    .rdata_reg(bc_rdata),
    .flash_addr_reg(p_addr),
    .dq_out_reg(p_dq),
    .dq_oe_n_reg(p_oe_n),
    .chip_sel_n_reg(p_ce_n),
    .out_en_n_reg(p_out_n),
    .wr_strobe_n_reg(p_we_n)
  );

  // pins go out through one more flop each
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flash_addr_reg <= 18'h00000;
      dq_out_reg <= 8'h00;
      dq_oe_n_reg <= 1'b1;
      chip_sel_n_reg <= 1'b1;
      out_en_n_reg <= 1'b1;
      wr_strobe_n_reg <= 1'b1;
      tlf_s1_reg <= 1'b0;
      tlf_s2_reg <= 1'b0;
    end else if (clk_en) begin
      flash_addr_reg <= p_addr;
      dq_out_reg <= p_dq;
      dq_oe_n_reg <= p_oe_n;
      chip_sel_n_reg <= p_ce_n;
      out_en_n_reg <= p_out_n;
      wr_strobe_n_reg <= p_we_n;
      tlf_s1_reg <= timing_limit_flag;
      tlf_s2_reg <= tlf_s1_reg;
    end
  end

  // command sequencer
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      op_reg <= `FMC_OP_READ;
      addr_reg <= 18'h00000;
      data_reg <= 8'h00;
      step_reg <= 2'h0;
      bc_start_reg <= 1'b0;
      bc_write_reg <= 1'b0;
      bc_addr_reg <= 18'h00000;
      bc_wdata_reg <= 8'h00;
      cmd_ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      id_mode_reg <= 1'b0;
      unprot_tmp_reg <= 1'b0;
      hv_addr_line_nine_reg <= 1'b0;
      hv_out_en_reg <= 1'b0;
      hv_reset_reg <= 1'b0;
      tlf_seen_reg <= 1'b0;
    end else if (clk_en) begin
      bc_start_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      // latched flag keeps reads gated until reset
      if (tlf_s2_reg)
        tlf_seen_reg <= 1'b1;
      case (state_reg)
        ST_IDLE: begin
          cmd_ready_reg <= 1'b1;
          if (cmd_valid && cmd_ready_reg) begin
            cmd_ready_reg <= 1'b0;
            op_reg <= cmd_op;
            addr_reg <= cmd_addr;
            data_reg <= cmd_data;
            step_reg <= 2'h0;
            state_reg <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          state_reg <= ST_BUS;
          bc_write_reg <= 1'b1;
          case (op_reg)
            `FMC_OP_ID_HV: begin
              // qualifier on line nine, plain read
              hv_addr_line_nine_reg <= 1'b1;
              bc_write_reg <= 1'b0;
              bc_addr_reg <= id_addr(data_reg[2:0], addr_reg);
            end
            `FMC_OP_ID_CMD: begin
              // two unlocks, identify command, then read
              bc_write_reg <= (step_reg != 2'h3);
              if (step_reg == 2'h0) begin
                bc_addr_reg <= `FMC_UNLOCK1_ADDR;
                bc_wdata_reg <= `FMC_UNLOCK1_DATA;
              end else if (step_reg == 2'h1) begin
                bc_addr_reg <= `FMC_UNLOCK2_ADDR;
                bc_wdata_reg <= `FMC_UNLOCK2_DATA;
              end else if (step_reg == 2'h2) begin
                bc_addr_reg <= `FMC_UNLOCK1_ADDR;
                bc_wdata_reg <= `FMC_ID_CMD_DATA;
              end else begin
                bc_addr_reg <= id_addr(data_reg[2:0], addr_reg);
              end
            end
            `FMC_OP_RESET: begin
              // address ignored by the device
              bc_addr_reg <= addr_reg;
              bc_wdata_reg <= `FMC_RESET_DATA;
            end
            `FMC_OP_PROTECT: begin
              // equipment pulse: qualifiers on line nine and oe
              hv_addr_line_nine_reg <= 1'b1;
              hv_out_en_reg <= 1'b1;
              bc_addr_reg <= {addr_reg[`FMC_SECT_MSB:`FMC_SECT_LSB], 12'h000};
              bc_wdata_reg <= data_reg;
            end
            `FMC_OP_UNPROT_TMP: begin
              // no bus cycle, reset pin qualifier only
              hv_reset_reg <= 1'b1;
              unprot_tmp_reg <= 1'b1;
              state_reg <= ST_DONE;
            end
            `FMC_OP_UNPROT_END: begin
              hv_reset_reg <= 1'b0;
              unprot_tmp_reg <= 1'b0;
              state_reg <= ST_DONE;
            end
            `FMC_OP_WRITE: begin
              bc_addr_reg <= addr_reg;
              bc_wdata_reg <= data_reg;
            end
            default: begin
              bc_write_reg <= 1'b0;
              bc_addr_reg <= addr_reg;
            end
          endcase
        end
        ST_BUS: begin
          bc_start_reg <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          // done pulse from the cycle engine ends the wait
          if (bc_done && !bc_busy) begin
            hv_out_en_reg <= 1'b0;
            if (op_reg == `FMC_OP_ID_CMD && step_reg != 2'h3) begin
              step_reg <= step_reg + 2'h1;
              state_reg <= ST_NEXT;
            end else begin
              state_reg <= ST_DONE;
            end
          end
        end
        default: begin
          rsp_valid_reg <= 1'b1;
          rsp_data_reg <= bc_rdata;
          if (op_reg == `FMC_OP_ID_HV || op_reg == `FMC_OP_PROTECT)
            hv_addr_line_nine_reg <= 1'b0;
          // id mode stays until the reset command
          if (op_reg == `FMC_OP_ID_CMD)
            id_mode_reg <= 1'b1;
          else if (op_reg == `FMC_OP_RESET) begin
            id_mode_reg <= 1'b0;
            tlf_seen_reg <= tlf_s2_reg;
          end
          if (op_reg == `FMC_OP_READ && tlf_seen_reg)
            rsp_data_reg <= 8'h00;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // fmc_host_ctrl
`default_nettype wire

// *** tb/fmc_checker_assertions.sv ***
// concurrent checks on the flash mode controller ports
`timescale 1ns/1ps
`default_nettype none
module fmc_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire logic cmd_ready_reg,
  input wire logic rsp_valid_reg,
  input wire logic id_mode_reg,
  input wire logic unprot_tmp_reg,
  input wire logic [17:0] flash_addr_reg,
  input wire logic [7:0] dq_out_reg,
  input wire logic dq_oe_n_reg,
  input wire logic chip_sel_n_reg,
  input wire logic out_en_n_reg,
  input wire logic wr_strobe_n_reg,
  input wire logic hv_addr_line_nine_reg,
  input wire logic hv_out_en_reg,
  input wire logic hv_reset_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // a request is taken on this cycle
  wire take = clk_en && cmd_valid && cmd_ready_reg;

  a_take_drops_ready: assert property (take |=> !cmd_ready_reg)
    else $error("ready stayed high after a take");
  a_answer_bounded: assert property (take |-> ##[1:80] rsp_valid_reg)
    else $error("no answer after a take");
  a_rsp_one_pulse: assert property (rsp_valid_reg |=> !rsp_valid_reg)
    else $error("answer pulse longer than one cycle");
  a_write_oe_high: assert property (!wr_strobe_n_reg |->
    out_en_n_reg && !chip_sel_n_reg)
    else $error("write strobe without select or with oe low");
  a_data_at_rise: assert property ($rose(wr_strobe_n_reg) |->
    !chip_sel_n_reg && !dq_oe_n_reg && $stable(dq_out_reg))
    else $error("data not held at strobe rise");
  a_addr_held: assert property (!chip_sel_n_reg && !$past(chip_sel_n_reg)
    |-> $stable(flash_addr_reg))
    else $error("address moved while selected");
  a_no_bus_fight: assert property (!out_en_n_reg |-> dq_oe_n_reg)
    else $error("host drives data while oe low");
  a_protect_qual: assert property (hv_out_en_reg |->
    hv_addr_line_nine_reg)
    else $error("oe qualifier without line nine qualifier");
  a_unprot_follow: assert property ($rose(hv_reset_reg) |->
    ##[0:1] unprot_tmp_reg)
    else $error("unprotect flag not following reset qualifier");

  c_id_mode: cover property ($rose(id_mode_reg));
  c_protect: cover property ($rose(hv_out_en_reg));
  c_unprot: cover property ($rose(hv_reset_reg));
endmodule // fmc_checker

bind fmc_host_ctrl fmc_checker u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready_reg(cmd_ready_reg),
  .rsp_valid_reg(rsp_valid_reg), .id_mode_reg(id_mode_reg),
  .unprot_tmp_reg(unprot_tmp_reg), .flash_addr_reg(flash_addr_reg),
  .dq_out_reg(dq_out_reg), .dq_oe_n_reg(dq_oe_n_reg),
  .chip_sel_n_reg(chip_sel_n_reg), .out_en_n_reg(out_en_n_reg),
  .wr_strobe_n_reg(wr_strobe_n_reg),
  .hv_addr_line_nine_reg(hv_addr_line_nine_reg),
  .hv_out_en_reg(hv_out_en_reg), .hv_reset_reg(hv_reset_reg));
`default_nettype wire

// *** tb/fmc_flash_model.sv ***
// behavioural flash device answering the controller's strobes
`timescale 1ns/1ps
`default_nettype none
`include "fmc_regs.vh"
module fmc_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC5, // arbitrary value
  parameter logic [7:0] PGM_CMD = 8'h5C, // program set-up code
  parameter logic [7:0] SUSP_STATUS = 8'h80 // status byte when suspended
) (
  input wire logic [17:0] addr,
  input wire logic [7:0] din,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic wr_strobe_n,
  input wire logic hv_line_nine,
  input wire logic hv_out_en,
  input wire logic hv_reset,
  output wire logic [7:0] dout
);
  logic [63:0] prot = 64'h0;
  logic [1:0] seq = 2'h0;
  logic id_mode = 1'b0;
  logic wr_act = 1'b0;
  logic [17:0] lat = 18'h0;
  logic [7:0] rd_val;
  logic [7:0] last_q = 8'h0;
  logic [63:0] susp = 64'h0; // no erase runs here, so never suspended
  logic supply_ok = 1'b1; // above supply_lockout_threshold throughout
  logic pgm_valid = 1'b0;
  logic [17:0] pgm_addr = 18'h0;
  logic [7:0] pgm_data = 8'h0;
  realtime t_fall = 0.0;
  wire ok_pgm = lat == `FMC_UNLOCK1_ADDR && din == PGM_CMD;
  wire ok1 = lat == `FMC_UNLOCK1_ADDR && din == `FMC_UNLOCK1_DATA;
  wire ok2 = lat == `FMC_UNLOCK2_ADDR && din == `FMC_UNLOCK2_DATA;
  wire ok3 = lat == `FMC_UNLOCK1_ADDR && din == `FMC_ID_CMD_DATA;

  // address taken when the later of the two selects falls
  always @(negedge wr_strobe_n or negedge chip_sel_n) begin
    if (supply_ok && !wr_strobe_n && !chip_sel_n && out_en_n) begin
      t_fall = $realtime;
      wr_act <= 1'b1;
      lat <= addr;
    end
  end

  // data taken on the first rising select; order errors drop the sequence
  always @(posedge wr_strobe_n or posedge chip_sel_n) begin
    if (wr_act) begin
      wr_act <= 1'b0;
      if ($realtime - t_fall < 5.0) begin
        seq <= seq; // glitch, no write
      end else if (hv_line_nine && hv_out_en) begin
        prot[lat[17:12]] <= 1'b1;
      end else if (din == `FMC_RESET_DATA) begin
        seq <= 2'h0;
        id_mode <= 1'b0;
      end else if (seq == 2'h0 && ok1) begin
        seq <= 2'h1;
      end else if (seq == 2'h1 && ok2) begin
        seq <= 2'h2;
      end else if (seq == 2'h2 && ok3) begin
        seq <= 2'h0;
        id_mode <= 1'b1;
      end else if (seq == 2'h2 && ok_pgm) begin
        seq <= 2'h3;
      end else if (seq == 2'h3) begin
        seq <= 2'h0;
        // protected sector keeps its data unless the reset pin is raised
        if (!prot[lat[17:12]] || hv_reset) begin
          pgm_valid <= 1'b1;
          pgm_addr <= lat;
          pgm_data <= din;
        end
      end else begin
        seq <= 2'h0;
      end
    end
  end

  // identifier codes by the low address bits, else an array pattern
  always @* begin
    if (hv_line_nine || id_mode) begin
      case (addr[1:0])
        2'h0: rd_val = MFR_CODE;
        2'h1: rd_val = DEV_CODE;
        default: rd_val = {7'h0, prot[addr[17:12]]};
      endcase
    end else if (susp[addr[17:12]]) begin
      rd_val = SUSP_STATUS;
    end else if (pgm_valid && addr == pgm_addr) begin
      rd_val = pgm_data;
    end else begin
      rd_val = addr[7:0] ^ 8'h5A;
    end
  end
  always @(posedge out_en_n) last_q <= rd_val;
  // released bus shows the inverse so a late sample cannot match
  assign dout = (!chip_sel_n && !out_en_n) ? rd_val : ~last_q;
endmodule // fmc_flash_model
`default_nettype wire

// *** tb/flash_mode_control_bench.sv ***
// self-checking bench for the flash mode controller
`timescale 1ns/1ps
`default_nettype none
`include "fmc_regs.vh"
module flash_mode_control_bench;
  localparam logic [7:0] MFR = 8'h3C; // arbitrary value
  localparam logic [7:0] DEV = 8'hC5; // arbitrary value
  localparam logic [7:0] PGM = 8'h5C; // program set-up code of the model
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [17:0] cmd_addr = 18'h0;
  logic [7:0] cmd_data = 8'h0;
  logic tlf = 1'b0;
  logic [7:0] got;
  int num_errors = 0;
  int samples_checked = 0;
  wire rdy, rsp_v, id_mode, unprot, dq_oe_n, ce_n, oe_n, we_n;
  wire hv9, hvoe, hvrst;
  wire [7:0] rsp_data, dq_out, dq_in;
  wire [17:0] faddr;

  initial forever #12.5 sys_clk = ~sys_clk;

  fmc_host_ctrl DUT (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_ready_reg(rdy), .rsp_valid_reg(rsp_v),
    .rsp_data_reg(rsp_data), .id_mode_reg(id_mode),
    .unprot_tmp_reg(unprot), .flash_addr_reg(faddr), .dq_in(dq_in),
    .dq_out_reg(dq_out), .dq_oe_n_reg(dq_oe_n), .chip_sel_n_reg(ce_n),
    .out_en_n_reg(oe_n), .wr_strobe_n_reg(we_n),
    .hv_addr_line_nine_reg(hv9), .hv_out_en_reg(hvoe),
    .hv_reset_reg(hvrst), .timing_limit_flag(tlf));

  fmc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .PGM_CMD(PGM))
    u_flash (.addr(faddr), .din(dq_out), .chip_sel_n(ce_n),
    .out_en_n(oe_n), .wr_strobe_n(we_n), .hv_line_nine(hv9),
    .hv_out_en(hvoe), .hv_reset(hvrst), .dout(dq_in));

  task automatic check8(input string what, input logic [7:0] exp,
      input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one user request, inputs moved on falling edges only
  task automatic do_op(input logic [2:0] op, input logic [17:0] a,
      input logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (rdy !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_v !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    check8("answer", 8'h01, {7'h0, rsp_v});
    got = rsp_data;
  endtask

  // unlock pair, program set-up, then the byte itself
  task automatic prog_byte(input logic [17:0] a, input logic [7:0] d);
    do_op(`FMC_OP_WRITE, `FMC_UNLOCK1_ADDR, `FMC_UNLOCK1_DATA);
    do_op(`FMC_OP_WRITE, `FMC_UNLOCK2_ADDR, `FMC_UNLOCK2_DATA);
    do_op(`FMC_OP_WRITE, `FMC_UNLOCK1_ADDR, PGM);
    do_op(`FMC_OP_WRITE, a, d);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    #(25 * 30000);
    num_errors++;
    $display("[ERR] watchdog expected done seen hang");
    conclude;
  end

  initial begin
    repeat (12) @(negedge sys_clk);
    resetn = 1'b1;
    check8("idle pins", 8'h0F, {4'h0, ce_n, oe_n, we_n, dq_oe_n});
    check8("idle hv", 8'h00, {5'h0, hv9, hvoe, hvrst});
    do_op(`FMC_OP_READ, 18'h00123, 8'h00);
    check8("array read", 8'h79, got);
    $display("test array read done");
    do_op(`FMC_OP_ID_HV, 18'h05000, 8'h00);
    check8("hv mfr", MFR, got);
    do_op(`FMC_OP_ID_HV, 18'h05000, 8'h01);
    check8("hv dev", DEV, got);
    do_op(`FMC_OP_ID_HV, 18'h05000, 8'h02);
    check8("hv prot before", 8'h00, got);
    do_op(`FMC_OP_PROTECT, 18'h05000, 8'h00);
    do_op(`FMC_OP_ID_HV, 18'h05000, 8'h02);
    check8("hv prot after", 8'h01, got);
    $display("test high voltage id done");
    do_op(`FMC_OP_ID_CMD, 18'h05000, 8'h02);
    check8("cmd prot set", 8'h01, got);
    check8("id mode", 8'h01, {7'h0, id_mode});
    do_op(`FMC_OP_ID_CMD, 18'h06000, 8'h02);
    check8("cmd prot clear", 8'h00, got);
    do_op(`FMC_OP_RESET, 18'h3FFFF, 8'h00);
    check8("id mode off", 8'h00, {7'h0, id_mode});
    do_op(`FMC_OP_READ, 18'h00000, 8'h00);
    check8("read after reset", 8'h5A, got);
    $display("test command id done");
    // unlock cycles out of order must leave the array visible
    do_op(`FMC_OP_WRITE, `FMC_UNLOCK1_ADDR, `FMC_UNLOCK1_DATA);
    do_op(`FMC_OP_WRITE, `FMC_UNLOCK1_ADDR, `FMC_ID_CMD_DATA);
    do_op(`FMC_OP_WRITE, `FMC_UNLOCK2_ADDR, `FMC_UNLOCK2_DATA);
    do_op(`FMC_OP_WRITE, `FMC_UNLOCK1_ADDR, `FMC_ID_CMD_DATA);
    do_op(`FMC_OP_READ, 18'h00001, 8'h00);
    check8("bad order read", 8'h5B, got);
    $display("test command order done");
    prog_byte(18'h05010, 8'h11);
    do_op(`FMC_OP_READ, 18'h05010, 8'h00);
    check8("protected program", 8'h4A, got);
    do_op(`FMC_OP_UNPROT_TMP, 18'h00000, 8'h00);
    check8("unprotect on", 8'h03, {6'h0, hvrst, unprot});
    prog_byte(18'h05010, 8'h11);
    do_op(`FMC_OP_UNPROT_END, 18'h00000, 8'h00);
    check8("unprotect off", 8'h00, {6'h0, hvrst, unprot});
    do_op(`FMC_OP_READ, 18'h05010, 8'h00);
    check8("unprotected program", 8'h11, got);
    prog_byte(18'h05020, 8'h22);
    do_op(`FMC_OP_READ, 18'h05020, 8'h00);
    check8("reprotected program", 8'h7A, got);
    $display("test temporary unprotect done");
    tlf = 1'b1;
    repeat (4) @(negedge sys_clk);
    tlf = 1'b0;
    do_op(`FMC_OP_READ, 18'h00010, 8'h00);
    check8("flagged read", 8'h00, got);
    do_op(`FMC_OP_RESET, 18'h00010, 8'h00);
    do_op(`FMC_OP_READ, 18'h00010, 8'h00);
    check8("cleared read", 8'h4A, got);
    $display("test timing limit done");
    conclude;
  end
endmodule // flash_mode_control_bench
`default_nettype wire
